// ==== pkg/chgrp_pkg.sv ====
// shared constants for the channel group register map and its host end
package chgrp_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register map geometry
  localparam int          GROUPS     = 8;
  localparam int          GRP_W      = 3;
  localparam int          BAR_HI_W   = 12;
  localparam logic [10:0] OFF_GBASE  = 11'h000;
  localparam logic [10:0] OFF_DAC    = 11'h004;
  localparam logic [10:0] OFF_SVC    = 11'h008;
  localparam logic [10:0] OFF_ISTAT  = 11'h00c;
  localparam logic [10:0] OFF_TXTS   = 11'h200;
  localparam logic [10:0] OFF_TXSUB  = 11'h280;
  localparam logic [10:0] OFF_TXCFG  = 11'h380;
  localparam logic [10:0] OFF_RXTS   = 11'h400;
  localparam logic [10:0] OFF_RXSUB  = 11'h480;
  localparam logic [10:0] OFF_RXCFG  = 11'h580;
  localparam logic [10:0] OFF_GCFG   = 11'h600;
  localparam logic [10:0] OFF_IQ     = 11'h604;
  localparam logic [10:0] OFF_IQ_HI  = 11'h608;
  localparam logic [10:0] OFF_GRPCFG = 11'h60c;
  localparam logic [10:0] OFF_MPROT  = 11'h610;
  localparam logic [10:0] OFF_MLEN   = 11'h614;
  localparam logic [10:0] OFF_PCFG   = 11'h618;
  localparam logic [10:0] OFF_WO_END = 11'h37c;
  localparam logic [10:0] OFF_RAM_END = 11'h5fc;
  localparam logic [10:0] BLK_STEP   = 11'h080;
  localparam logic [10:0] WORD_STEP  = 11'h004;
  localparam logic [31:0] ALL_ONES   = 32'hffff_ffff;
  ////////////////////////////////////////////////////////////////////////
  // service request word
  localparam int SVC_OP_LSB  = 0;
  localparam int SVC_BLK_LSB = 3;
  localparam int SVC_CH_LSB  = 5;
  typedef enum logic [2:0] {
    SVC_NONE        = 3'h0,
    SVC_LOAD_IMG    = 3'h1,
    SVC_LOAD_GLOBAL = 3'h2,
    SVC_FETCH_PTR   = 3'h3
  } svc_op_e;
  ////////////////////////////////////////////////////////////////////////
  // host end apb registers
  localparam logic [7:0] H_CTRL  = 8'h00;
  localparam logic [7:0] H_ADDR  = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STAT  = 8'h10;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_WE    = 1;
  localparam int CTRL_MEM   = 2;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_TMO   = 1;
  localparam int STAT_REFUS = 2;
  localparam logic [7:0] TGT_TMO_CYC = 8'h20;
endpackage : chgrp_pkg

// ==== pkg/chgrp_if.sv ====
// link between the host end and the channel group register map
`timescale 1ns/100ps
interface chgrp_if;
  logic        t_req;
  logic        t_we;
  logic [31:0] t_addr;
  logic [31:0] t_wdata;
  logic        t_ack;
  logic [31:0] t_rdata;
  logic        m_req;
  logic [31:0] m_addr;
  logic        m_ack;
  logic [31:0] m_rdata;
  modport dev  (input t_req, t_we, t_addr, t_wdata, m_ack, m_rdata, output t_ack, t_rdata, m_req, m_addr);
  modport host (output t_req, t_we, t_addr, t_wdata, m_ack, m_rdata, input t_ack, t_rdata, m_req, m_addr);
endinterface : chgrp_if

// ==== src/chgrp_regmap.sv ====
// channel group register map: target decode, internal image, service fetch engine
// Contract
// - common registers alias groups 1-7 to group 0
// - host avoids internal RAM while channels active
// - RAM changes go through service request loads; target writes also change it directly
// - first four group registers directly host accessible
// - device runs from internal values only
// - service request write triggers image fetch
// - transmit maps write only, reads return ones
// - target for requests, master for fetches
// - host builds shared memory before loading
// - descriptors valid before activation, unchecked
// - pointers fetched from 128-byte blocks, uncached
// - image fetched from fixed group-base offsets
// - group base pointers 2 kB aligned
// - base pointers written by plain writes
// - claim only when top 12 bits match
`timescale 1ns/100ps
module chgrp_regmap #(
  parameter int GROUPS = chgrp_pkg::GROUPS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // link
  chgrp_if.dev             link,
  // user side
  input  wire logic [31:0] bar_i,
  output logic             busy_o,
  output logic [31:0]      ptr_o,
  output logic             ptr_valid_o,
  output logic [31:0]      glob_cfg_o,
  output logic [31:0]      port_cfg_o
);
  if (GROUPS < 1 || GROUPS > 8) begin : g_chk
    $error("GROUPS must be 1 to 8");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_REQ  = 3'b010,
    S_GAP  = 3'b100
  } fsm_e;

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0]       img_q [GROUPS*512];
  logic [31:0]       gbase_q [GROUPS];
  logic [31:0]       svc_q [GROUPS];
  logic [GROUPS-1:0] pend_q;
  logic [31:0]       dac_q;
  logic [31:0]       istat_q;
  fsm_e              st_q;
  logic [2:0]        cur_grp_q;
  logic [2:0]        op_q;
  logic [10:0]       off_q;
  logic [10:0]       end_q;
  logic              t_ack_q;
  logic [31:0]       t_rdata_q;
  logic              m_req_q;
  logic [31:0]       m_addr_q;

  function automatic logic is_common(input logic [10:0] off);
    is_common = (off == chgrp_pkg::OFF_DAC) || (off == chgrp_pkg::OFF_ISTAT) ||
                (off == chgrp_pkg::OFF_GCFG) || (off == chgrp_pkg::OFF_IQ) ||
                (off == chgrp_pkg::OFF_IQ_HI);
  endfunction : is_common

  ////////////////////////////////////////////////////////////////////////
  // target decode
  logic [10:0] t_off;
  logic [2:0]  t_grp;
  logic [2:0]  t_egrp;
  logic        in_map;
  logic        claim;
  logic        fetch_wr;
  logic        tgt_wr;
  logic        in_img;
  logic [2:0]  cur_sel;
  logic [2:0]  sel_op;
  logic [1:0]  sel_blk;
  logic [4:0]  sel_ch;

  assign t_off    = link.t_addr[10:0];
  assign t_grp    = link.t_addr[13:11];
  assign t_egrp   = is_common(t_off) ? 3'h0 : t_grp;
  assign in_map   = (link.t_addr[19:14] == 6'h00) && (32'(t_grp) < GROUPS);
  assign in_img   = (t_off >= chgrp_pkg::OFF_TXTS) && (t_off <= chgrp_pkg::OFF_PCFG);
  assign fetch_wr = (st_q == S_REQ) && link.m_ack && (op_q != 3'(chgrp_pkg::SVC_FETCH_PTR));
  // fetch owns the image write port; a clashing target cycle waits a clock
  assign claim    = link.t_req && !t_ack_q && !fetch_wr &&
                    (link.t_addr[31:20] == bar_i[31:20]);
  assign tgt_wr   = claim && link.t_we && in_map;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t_ack_q   <= 1'b0;
      t_rdata_q <= 32'h0000_0000;
    end else if (claim) begin
      t_ack_q   <= 1'b1;
      t_rdata_q <= 32'h0000_0000;
      if (!link.t_we && in_map) begin
        if (t_off == chgrp_pkg::OFF_GBASE) begin
          t_rdata_q <= gbase_q[t_grp];
        end else if (t_off == chgrp_pkg::OFF_DAC) begin
          t_rdata_q <= dac_q;
        end else if (t_off == chgrp_pkg::OFF_SVC) begin
          t_rdata_q <= svc_q[t_grp];
        end else if (t_off == chgrp_pkg::OFF_ISTAT) begin
          t_rdata_q <= istat_q;
        end else if (t_off >= chgrp_pkg::OFF_TXTS && t_off <= chgrp_pkg::OFF_WO_END) begin
          t_rdata_q <= chgrp_pkg::ALL_ONES;
        end else if (in_img) begin
          t_rdata_q <= img_q[{t_egrp, t_off[10:2]}];
        end
      end
    end else begin
      t_ack_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // directly held registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dac_q   <= 32'h0000_0000;
      istat_q <= 32'h0000_0000;
    end else if (tgt_wr && t_off == chgrp_pkg::OFF_DAC) begin
      dac_q   <= link.t_wdata;
    end else if (tgt_wr && t_off == chgrp_pkg::OFF_ISTAT) begin
      istat_q <= link.t_wdata;
    end
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    logic take;
    logic wr_svc;
    assign take   = (st_q == S_IDLE) && (cur_sel == 3'(g)) && pend_q[g];
    assign wr_svc = tgt_wr && (t_off == chgrp_pkg::OFF_SVC) && (t_grp == 3'(g));
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        gbase_q[g] <= 32'h0000_0000;
        svc_q[g]   <= 32'h0000_0000;
        pend_q[g]  <= 1'b0;
      end else begin
        if (tgt_wr && t_off == chgrp_pkg::OFF_GBASE && t_grp == 3'(g)) begin
          gbase_q[g] <= link.t_wdata;
        end
        if (wr_svc) begin
          svc_q[g]  <= link.t_wdata;
          pend_q[g] <= 1'b1;
        end else if (take) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal image; no reset, contents undefined until loaded
  logic [2:0] f_egrp;
  assign f_egrp = is_common(off_q) ? 3'h0 : cur_grp_q;

  always_ff @(posedge clk_i) begin
    if (fetch_wr) begin
      img_q[{f_egrp, off_q[10:2]}] <= link.m_rdata;
    end else if (tgt_wr && in_img && !(t_off <= chgrp_pkg::OFF_WO_END && t_off >= chgrp_pkg::OFF_TXTS)) begin
      img_q[{t_egrp, t_off[10:2]}] <= link.t_wdata;
    end else if (tgt_wr && in_img) begin
      img_q[{t_grp, t_off[10:2]}] <= link.t_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service fetch engine, lowest pending group first

  always_comb begin
    cur_sel = 3'h0;
    for (int i = GROUPS - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        cur_sel = 3'(i);
      end
    end
  end

  assign sel_op  = svc_q[cur_sel][chgrp_pkg::SVC_OP_LSB +: 3];
  assign sel_blk = svc_q[cur_sel][chgrp_pkg::SVC_BLK_LSB +: 2];
  assign sel_ch  = svc_q[cur_sel][chgrp_pkg::SVC_CH_LSB +: 5];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q      <= S_IDLE;
      cur_grp_q <= 3'h0;
      op_q      <= 3'h0;
      off_q     <= 11'h000;
      end_q     <= 11'h000;
      m_req_q   <= 1'b0;
      m_addr_q  <= 32'h0000_0000;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (|pend_q && sel_op != 3'(chgrp_pkg::SVC_NONE) && sel_op <= 3'(chgrp_pkg::SVC_FETCH_PTR)) begin
            cur_grp_q <= cur_sel;
            op_q      <= sel_op;
            st_q      <= S_REQ;
            m_req_q   <= 1'b1;
            if (sel_op == 3'(chgrp_pkg::SVC_LOAD_IMG)) begin
              off_q    <= chgrp_pkg::OFF_TXTS;
              end_q    <= chgrp_pkg::OFF_PCFG;
              m_addr_q <= gbase_q[cur_sel] + {21'h0, chgrp_pkg::OFF_TXTS};
            end else if (sel_op == 3'(chgrp_pkg::SVC_LOAD_GLOBAL)) begin
              off_q    <= chgrp_pkg::OFF_GCFG;
              end_q    <= chgrp_pkg::OFF_GCFG;
              m_addr_q <= gbase_q[cur_sel] + {21'h0, chgrp_pkg::OFF_GCFG};
            end else begin
              // pointer read goes out only; nothing kept in the image
              off_q    <= 11'(sel_blk) * chgrp_pkg::BLK_STEP + {4'h0, sel_ch, 2'b00};
              end_q    <= 11'h000;
              m_addr_q <= gbase_q[cur_sel] + {21'h0, 11'(sel_blk) * chgrp_pkg::BLK_STEP} +
                          {25'h0, sel_ch, 2'b00};
            end
          end
        end
        S_REQ: begin
          if (link.m_ack) begin
            m_req_q <= 1'b0;
            if (op_q == 3'(chgrp_pkg::SVC_FETCH_PTR) || off_q == end_q) begin
              st_q <= S_IDLE;
            end else begin
              off_q    <= off_q + chgrp_pkg::WORD_STEP;
              m_addr_q <= m_addr_q + 32'h0000_0004;
              st_q     <= S_GAP;
            end
          end
        end
        S_GAP: begin
          m_req_q <= 1'b1;
          st_q    <= S_REQ;
        end
        default: begin
          st_q    <= S_IDLE;
          m_req_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user side outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_o       <= 32'h0000_0000;
      ptr_valid_o <= 1'b0;
    end else begin
      ptr_valid_o <= (st_q == S_REQ) && link.m_ack && (op_q == 3'(chgrp_pkg::SVC_FETCH_PTR));
      if ((st_q == S_REQ) && link.m_ack && (op_q == 3'(chgrp_pkg::SVC_FETCH_PTR))) begin
        ptr_o <= link.m_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o     <= 1'b0;
      glob_cfg_o <= 32'h0000_0000;
      port_cfg_o <= 32'h0000_0000;
    end else begin
      busy_o     <= (st_q != S_IDLE) || (|pend_q);
      glob_cfg_o <= img_q[{3'h0, chgrp_pkg::OFF_GCFG[10:2]}];
      port_cfg_o <= img_q[{3'h0, chgrp_pkg::OFF_PCFG[10:2]}];
    end
  end

  assign link.t_ack   = t_ack_q;
  assign link.t_rdata = t_rdata_q;
  assign link.m_req   = m_req_q;
  assign link.m_addr  = m_addr_q;
endmodule : chgrp_regmap

// ==== src/chgrp_host.sv ====
// host end: apb command registers, target cycles out, shared memory answers in
`timescale 1ns/100ps
module chgrp_host #(
  parameter int SMEM_AW = 10
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // system state
  input  wire logic        chan_active_i,
  // link
  chgrp_if.host            link
);
  if (SMEM_AW < 2 || SMEM_AW > 16) begin : g_chk
    $error("SMEM_AW must be 2 to 16");
  end

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } hst_e;

  logic [31:0] smem_q [2**SMEM_AW];
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        tmo_q;
  logic        refus_q;
  hst_e        st_q;
  logic [7:0]  cnt_q;
  logic        t_req_q;
  logic        t_we_q;
  logic        m_ack_q;
  logic [31:0] m_rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // apb with one wait state so all answers come from flops
  logic acc;
  logic wr;
  logic go;
  logic bad;
  logic mapped;
  assign acc    = psel_i && penable_i && pready_o;
  assign wr     = acc && pwrite_i;
  assign go     = wr && (paddr_i == chgrp_pkg::H_CTRL) && pwdata_i[chgrp_pkg::CTRL_GO] &&
                  !pwdata_i[chgrp_pkg::CTRL_MEM] && (st_q == H_IDLE);
  assign mapped = (paddr_i <= chgrp_pkg::H_STAT) && (paddr_i[1:0] == 2'b00);
  // unaligned base or internal RAM touched during traffic is never sent
  assign bad    = (pwdata_i[chgrp_pkg::CTRL_WE] && addr_q[10:0] == chgrp_pkg::OFF_GBASE &&
                   wdata_q[10:0] != 11'h000) ||
                  (chan_active_i && addr_q[10:0] >= chgrp_pkg::OFF_TXTS &&
                   addr_q[10:0] <= chgrp_pkg::OFF_RAM_END);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= !mapped;
      case (paddr_i)
        chgrp_pkg::H_ADDR:  prdata_o <= addr_q;
        chgrp_pkg::H_WDATA: prdata_o <= wdata_q;
        chgrp_pkg::H_RDATA: prdata_o <= rdata_q;
        chgrp_pkg::H_STAT:  prdata_o <= {29'h0, refus_q, tmo_q, st_q == H_WAIT};
        default:            prdata_o <= 32'h0000_0000;
      endcase
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end else if (wr && paddr_i == chgrp_pkg::H_ADDR) begin
      addr_q  <= pwdata_i;
    end else if (wr && paddr_i == chgrp_pkg::H_WDATA) begin
      wdata_q <= pwdata_i;
    end
  end

  // shared memory: software builds images here first
  always_ff @(posedge clk_i) begin
    if (wr && paddr_i == chgrp_pkg::H_CTRL && pwdata_i[chgrp_pkg::CTRL_MEM]) begin
      smem_q[addr_q[SMEM_AW+1:2]] <= wdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // target cycle master; timeout stands in for an unclaimed cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q    <= H_IDLE;
      cnt_q   <= 8'h00;
      t_req_q <= 1'b0;
      t_we_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (go && !bad) begin
            t_req_q <= 1'b1;
            t_we_q  <= pwdata_i[chgrp_pkg::CTRL_WE];
            cnt_q   <= 8'h00;
            st_q    <= H_WAIT;
          end
        end
        H_WAIT: begin
          cnt_q <= cnt_q + 8'h01;
          if (link.t_ack) begin
            t_req_q <= 1'b0;
            rdata_q <= link.t_rdata;
            st_q    <= H_IDLE;
          end else if (cnt_q == chgrp_pkg::TGT_TMO_CYC) begin
            t_req_q <= 1'b0;
            rdata_q <= chgrp_pkg::ALL_ONES;
            st_q    <= H_IDLE;
          end
        end
        default: begin
          st_q    <= H_IDLE;
          t_req_q <= 1'b0;
        end
      endcase
    end
  end

  // sticky flags, set wins over write-one-to-clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmo_q   <= 1'b0;
      refus_q <= 1'b0;
    end else begin
      if (st_q == H_WAIT && !link.t_ack && cnt_q == chgrp_pkg::TGT_TMO_CYC) begin
        tmo_q <= 1'b1;
      end else if (wr && paddr_i == chgrp_pkg::H_STAT && pwdata_i[chgrp_pkg::STAT_TMO]) begin
        tmo_q <= 1'b0;
      end
      if (go && bad) begin
        refus_q <= 1'b1;
      end else if (wr && paddr_i == chgrp_pkg::H_STAT && pwdata_i[chgrp_pkg::STAT_REFUS]) begin
        refus_q <= 1'b0;
      end
    end
  end

  // shared memory read answers for the device's fetches
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_ack_q   <= 1'b0;
      m_rdata_q <= 32'h0000_0000;
    end else if (link.m_req && !m_ack_q) begin
      m_ack_q   <= 1'b1;
      m_rdata_q <= smem_q[link.m_addr[SMEM_AW+1:2]];
    end else begin
      m_ack_q <= 1'b0;
    end
  end

  assign link.t_req   = t_req_q;
  assign link.t_we    = t_we_q;
  assign link.t_addr  = addr_q;
  assign link.t_wdata = wdata_q;
  assign link.m_ack   = m_ack_q;
  assign link.m_rdata = m_rdata_q;
endmodule : chgrp_host

// ==== test/chgrp_properties.sv ====
// link checks between host end and channel group register map
`timescale 1ns/100ps
module chgrp_properties #(
  parameter logic [11:0] BAR_HI = 12'h000
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // target side
  input wire logic        t_req,
  input wire logic        t_we,
  input wire logic [31:0] t_addr,
  input wire logic [31:0] t_wdata,
  input wire logic        t_ack,
  input wire logic [31:0] t_rdata,
  // fetch side
  input wire logic        m_req,
  input wire logic [31:0] m_addr,
  input wire logic        m_ack,
  input wire logic [31:0] m_rdata
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////
  a_ack_has_req: assert property (t_ack |-> t_req)
    else $error("target answer without request");
  a_ack_one_cycle: assert property (t_ack |=> !t_ack)
    else $error("target answer longer than one cycle");
  a_no_foreign_claim: assert property ((!t_req || t_addr[31:20] != BAR_HI) |=> !t_ack)
    else $error("cycle claimed without address match");
  a_claim_bounded: assert property ($rose(t_req) && t_addr[31:20] == BAR_HI |-> ##[1:8] t_ack)
    else $error("matching cycle not answered");
  a_wo_reads_ones: assert property (t_ack && !t_we && t_addr[19:14] == 6'h00
      && t_addr[10:0] >= chgrp_pkg::OFF_TXTS && t_addr[10:0] <= chgrp_pkg::OFF_WO_END
      |-> t_rdata == chgrp_pkg::ALL_ONES)
    else $error("write only area read not all ones");
  a_mreq_holds: assert property (m_req && !m_ack |=> m_req && $stable(m_addr))
    else $error("fetch request dropped or moved early");
  a_mreq_drops: assert property (m_req && m_ack |=> !m_req)
    else $error("fetch request kept after answer");
  a_fetch_step: assert property ($rose(m_req) && $past(m_req, 2) |-> m_addr == $past(m_addr, 2) + 32'h4)
    else $error("image fetch address not one word on");
  a_fetch_inside: assert property (m_req |-> m_addr[1:0] == 2'h0 && m_addr[10:0] <= chgrp_pkg::OFF_PCFG)
    else $error("fetch address outside group structure");
endmodule : chgrp_properties

// ==== test/channel_group_register_map_bench.sv ====
// self-checking bench joining host end and register map
`timescale 1ns/100ps
module channel_group_register_map_bench;
  localparam logic [31:0] BAR = 32'h0a50_0000;
  logic        clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, chan_act, busy, ptr_valid, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, ptr, glob_cfg, port_cfg, rd, v, old, ptr_seen;
  logic [31:0] smem_m [int];
  int          error_cnt, checks_done, seed;
  int          com[5] = '{'h004, 'h00c, 'h600, 'h604, 'h608};
  int          wo[4] = '{'h200, 'h27c, 'h280, 'h37c};
  int          img[9] = '{'h380, 'h400, 'h4fc, 'h480, 'h580, 'h60c, 'h610, 'h614, 'h618};
  chgrp_if link();
  chgrp_regmap #(.GROUPS(8)) i_chgrp_regmap (.clk_i(clk_i), .nrst_i(nrst_i), .link(link), .bar_i(BAR),
    .busy_o(busy), .ptr_o(ptr), .ptr_valid_o(ptr_valid), .glob_cfg_o(glob_cfg), .port_cfg_o(port_cfg));
  chgrp_host #(.SMEM_AW(10)) i_chgrp_host (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .chan_active_i(chan_act), .link(link));
  chgrp_properties #(.BAR_HI(BAR[31:20])) i_chgrp_properties (.clk_i(clk_i), .nrst_i(nrst_i),
    .t_req(link.t_req), .t_we(link.t_we), .t_addr(link.t_addr), .t_wdata(link.t_wdata), .t_ack(link.t_ack),
    .t_rdata(link.t_rdata), .m_req(link.m_req), .m_addr(link.m_addr), .m_ack(link.m_ack),
    .m_rdata(link.m_rdata));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (ptr_valid === 1'b1) ptr_seen = ptr;
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held until the edge that samples pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      results();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task tgt(input logic we, input logic [31:0] a, input logic [31:0] wd);
    int n;
    apb(1'b1, chgrp_pkg::H_ADDR, a);
    apb(1'b1, chgrp_pkg::H_WDATA, wd);
    apb(1'b1, chgrp_pkg::H_CTRL, {30'h0, we, 1'b1});
    n = 0;
    do begin
      apb(1'b0, chgrp_pkg::H_STAT, 32'h0);
      n++;
    end while (rd[chgrp_pkg::STAT_BUSY] !== 1'b0 && n < 32);
    if (n >= 32) begin
      error_cnt++;
      results();
    end
    apb(1'b0, chgrp_pkg::H_RDATA, 32'h0);
  endtask : tgt
  task mem(input int a, input logic [31:0] d);
    smem_m[a] = d;
    apb(1'b1, chgrp_pkg::H_ADDR, 32'(a));
    apb(1'b1, chgrp_pkg::H_WDATA, d);
    apb(1'b1, chgrp_pkg::H_CTRL, 32'h4);
  endtask : mem
  // fetch time depends on the op, so wait on busy with a bound
  task svc(input int g, input logic [31:0] w);
    int n;
    tgt(1'b1, BAR | 32'(g << 11) | 32'h8, w);
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      results();
    end
  endtask : svc
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2c5408dd;
    error_cnt = 0;
    checks_done = 0;
    {nrst_i, psel, penable, pwrite, chan_act} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ptr_seen = 32'h0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    tgt(1'b1, BAR, 32'h800);
    tgt(1'b0, BAR, 32'h0);
    chk("group 0 base", 32'h800, rd);
    tgt(1'b1, BAR | 32'h800, 32'h1000);
    tgt(1'b0, BAR | 32'h800, 32'h0);
    chk("group 1 base", 32'h1000, rd);
    $display("test base pointers done");
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      tgt(1'b1, BAR | 32'((i + 1) << 11) | 32'(com[i]), v);
      tgt(1'b0, BAR | 32'(com[i]), 32'h0);
      chk("common reg", v, rd);
    end
    for (int i = 0; i < 4; i++) begin
      tgt(1'b1, BAR | 32'(i << 11) | 32'(wo[i]), $random(seed));
      tgt(1'b0, BAR | 32'(i << 11) | 32'(wo[i]), 32'h0);
      chk("write only map", chgrp_pkg::ALL_ONES, rd);
    end
    $display("test aliasing done");
    tgt(1'b0, BAR ^ 32'h0010_0000, 32'h0);
    chk("unclaimed read", chgrp_pkg::ALL_ONES, rd);
    apb(1'b0, chgrp_pkg::H_STAT, 32'h0);
    chk("timeout flag", 32'h1, {31'h0, rd[chgrp_pkg::STAT_TMO]});
    apb(1'b1, chgrp_pkg::H_STAT, 32'h6);
    chan_act <= 1'b1;
    tgt(1'b0, BAR | 32'h400, 32'h0);
    apb(1'b0, chgrp_pkg::H_STAT, 32'h0);
    chk("active refusal", 32'h1, {31'h0, rd[chgrp_pkg::STAT_REFUS]});
    chan_act <= 1'b0;
    apb(1'b1, chgrp_pkg::H_STAT, 32'h6);
    tgt(1'b1, BAR, 32'h804);
    tgt(1'b0, BAR, 32'h0);
    chk("misaligned base kept out", 32'h800, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    chk("unmapped read", 32'h0, rd);
    $display("test refusals done");
    for (int a = 'h200; a <= 'h618; a += 4) mem('h800 + a, $random(seed));
    svc(0, 32'h1);
    chk("global cfg out", smem_m['he00], glob_cfg);
    chk("port cfg out", smem_m['he18], port_cfg);
    for (int i = 0; i < 9; i++) begin
      tgt(1'b0, BAR | 32'(img[i]), 32'h0);
      chk("loaded image", smem_m['h800 + img[i]], rd);
    end
    old = smem_m['he00];
    mem('he00, $random(seed));
    chk("runs on internal copy", old, glob_cfg);
    svc(0, 32'h0);
    chk("empty request ignored", old, glob_cfg);
    svc(0, 32'h2);
    chk("global reload", smem_m['he00], glob_cfg);
    $display("test image load done");
    for (int i = 0; i < 3; i++) begin
      mem('h1000 + i * 'h80 + (31 - i * 13) * 4, $random(seed));
      svc(1, 32'h3 | 32'(i << 3) | 32'((31 - i * 13) << 5));
      chk("pointer fetch", smem_m['h1000 + i * 'h80 + (31 - i * 13) * 4], ptr_seen);
    end
    $display("test pointer fetch done");
    results();
  end
endmodule : channel_group_register_map_bench
